// [include/write_guard_defines.vh]
// Constants for the peripheral write guard: register map, fields, keys.
// Assumes inclusion by bare name from rtl files; definitions only.
`ifndef WRITE_GUARD_DEFINES_VH
`define WRITE_GUARD_DEFINES_VH

// Register byte offsets
`define CMD_OFFSET       8'h00
`define STATUS_OFFSET    8'h04
`define STATUS_ID_OFFSET 8'h08

// Command register fields
`define KEY_MSB          23
`define KEY_LSB          16
`define ID_MSB           15
`define ID_LSB           0
`define CMD_RESET        32'h00000000
`define CMD_WRITE_MASK   32'h00FFFFFF

// Key codes
`define KEY_OFF          8'h00
`define KEY_CLEAR        8'h01
`define KEY_SET          8'h02
`define KEY_LOCK         8'h03

// Identifier layout: bridge number times 32 plus index
`define BRIDGE_SHIFT     5
`define IDX_WIDTH        5
`define NUM_BRIDGES      4
`define NUM_PERIPH       128
`define PERIPH_AW        7

// AHB constants
`define HTRANS_NONSEQ    2'h2
`define HTRANS_SEQ       2'h3
`define HRESP_OKAY       1'h0
`define ZERO32           32'h00000000
`define ADDR_W           8

`endif

// [rtl/guard_state_mem.v]
// Per-peripheral protect and lock bits, one two-bit word per identifier.
// Assumes one clock; read data leave through a register one cycle later.
`timescale 1ns/1ps
`include "write_guard_defines.vh"

module guard_state_mem (
  // Clock and reset
  input  wire                    clk,
  input  wire                    reset,
  // Write port
  input  wire                    wrEn,
  input  wire [`PERIPH_AW-1:0]   wrAddr,
  input  wire                    wrProtect,
  input  wire                    wrLock,
  // Read port A (command path)
  input  wire [`PERIPH_AW-1:0]   rdAddrA,
  output reg  [1:0]              rdDataA_ff,
  // Read port B (status readback)
  input  wire [`PERIPH_AW-1:0]   rdAddrB,
  output reg  [1:0]              rdDataB_ff,
  // Flat protect vector for the peripherals
  output wire [`NUM_PERIPH-1:0]  protectVec
);

  reg [`NUM_PERIPH-1:0] protectBits_ff; // Write-protect state
  reg [`NUM_PERIPH-1:0] lockBits_ff;    // Lock state

  assign protectVec = protectBits_ff;

  // Storage; flops rather than RAM so reset clears every bit at once
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      protectBits_ff <= {`NUM_PERIPH{1'b0}};
      lockBits_ff    <= {`NUM_PERIPH{1'b0}};
    end else if (wrEn) begin
      protectBits_ff[wrAddr] <= wrProtect;
      lockBits_ff[wrAddr]    <= wrLock;
    end
  end

  // Registered read data
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rdDataA_ff <= 2'h0;
      rdDataB_ff <= 2'h0;
    end else begin
      rdDataA_ff <= {lockBits_ff[rdAddrA], protectBits_ff[rdAddrA]};
      rdDataB_ff <= {lockBits_ff[rdAddrB], protectBits_ff[rdAddrB]};
    end
  end

endmodule // guard_state_mem

// [rtl/peripheral_write_guard.v]
// Peripheral write guard: AHB-Lite command register driving protect/lock bits.
// Assumes a single AHB-Lite master on clk; hreadyout is the bus hready.
// What this block does
// - Key in bits 23:16; key 0 does nothing
// - Key 1 clears protection unless locked
// - Key 2 sets protection of selected peripheral
// - Key 3 sets and locks until reset
// - Bits 15:0 select the target peripheral
// - Identifier is 32 times bridge plus index
// - Bridges numbered from zero in order
// - Command register resets to all zeros
`timescale 1ns/1ps
`include "write_guard_defines.vh"

module peripheral_write_guard (
  // Clock and reset
  input  wire                    clk,
  input  wire                    reset,
  // AHB-Lite slave
  input  wire                    hsel,
  input  wire [`ADDR_W-1:0]      haddr,
  input  wire [1:0]              htrans,
  input  wire                    hwrite,
  input  wire [2:0]              hsize,
  input  wire                    hready,
  input  wire [31:0]             hwdata,
  output reg  [31:0]             hrdata,
  output wire                    hreadyout,
  output wire                    hresp,
  // Protection outputs per peripheral
  output wire [`NUM_PERIPH-1:0]  writeProtect,
  // High while the command engine is not idle
  output wire                    busyCmd
);

  // States of the command engine
  localparam ST_IDLE  = 2'h0; // Waiting for a command
  localparam ST_READ  = 2'h1; // Fetching target's current state
  localparam ST_APPLY = 2'h2; // Writing the new state

  reg  [31:0]            cmdReg_ff;       // Command register contents
  reg  [31:0]            nxt_cmdReg;
  reg  [1:0]             state_ff;        // Command engine state
  reg  [1:0]             nxt_state;
  reg                    wrPend_ff;       // Write data phase pending
  reg  [`ADDR_W-1:0]     addr_ff;         // Latched address phase
  reg  [`PERIPH_AW-1:0]  statusSel_ff;    // Status readback selector
  reg  [`PERIPH_AW-1:0]  nxt_statusSel;
  reg                    memWr;           // Memory write strobe
  reg                    memProt;         // New protect value
  reg                    memLock;         // New lock value
  reg                    cmdValid_ff;     // Target inside implemented range
  wire [1:0]             curState;        // {lock, protect} of the target
  wire [1:0]             statusState;     // {lock, protect} of status entry
  wire [7:0]             cmdKey;          // Key field
  wire [15:0]            cmdId;           // Identifier field
  wire                   addrPhase;       // Valid address phase

  // Bridge number from an identifier (upper bits)
  function [15:0] bridgeOf;
    input [15:0] id;
    begin
      bridgeOf = id >> `BRIDGE_SHIFT;
    end
  endfunction

  // Linear slot: bridge times 32 plus index, cut to memory width
  function [`PERIPH_AW-1:0] slotOf;
    input [15:0] id;
    reg   [15:0] lin;
    begin
      lin    = (bridgeOf(id) << `BRIDGE_SHIFT) + {11'h000, id[`IDX_WIDTH-1:0]};
      slotOf = lin[`PERIPH_AW-1:0];
    end
  endfunction

  assign cmdKey    = cmdReg_ff[`KEY_MSB:`KEY_LSB];
  assign cmdId     = cmdReg_ff[`ID_MSB:`ID_LSB];
  assign addrPhase = hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);
  // Stall writes while a command is still applying, so none is lost
  assign hreadyout = !(wrPend_ff && state_ff != ST_IDLE);
  assign hresp     = `HRESP_OKAY;
  assign busyCmd   = (state_ff != ST_IDLE);

  // Protection state storage; the status port reads the selector's next value,
  // so a status read right after a select write already sees the new entry
  guard_state_mem uMem (
    .clk        (clk),
    .reset      (reset),
    .wrEn       (memWr),
    .wrAddr     (slotOf(cmdId)),
    .wrProtect  (memProt),
    .wrLock     (memLock),
    .rdAddrA    (slotOf(cmdId)),
    .rdDataA_ff (curState),
    .rdAddrB    (nxt_statusSel),
    .rdDataB_ff (statusState),
    .protectVec (writeProtect)
  );

  // Address phase capture
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPend_ff <= 1'b0;
      addr_ff   <= {`ADDR_W{1'b0}};
    end else if (hreadyout) begin
      wrPend_ff <= addrPhase && hwrite;
      if (addrPhase) begin
        addr_ff <= haddr;
      end
    end
  end

  // Register writes and command engine next state
  always @* begin
    nxt_cmdReg    = cmdReg_ff;
    nxt_statusSel = statusSel_ff;
    nxt_state     = state_ff;
    memWr         = 1'b0;
    memProt       = curState[0];
    memLock       = curState[1];
    // Write data phase completes here
    if (wrPend_ff && hreadyout) begin
      if (addr_ff == `CMD_OFFSET) begin
        nxt_cmdReg = hwdata & `CMD_WRITE_MASK;
        nxt_state  = ST_READ;
      end else if (addr_ff == `STATUS_ID_OFFSET) begin
        nxt_statusSel = slotOf(hwdata[`ID_MSB:`ID_LSB]);
      end
    end
    case (state_ff)
      ST_IDLE: begin
      end
      ST_READ: begin
        // Memory read data arrive next cycle
        nxt_state = ST_APPLY;
      end
      ST_APPLY: begin
        nxt_state = ST_IDLE;
        if (cmdValid_ff && !curState[1]) begin
          // Locked entries never change
          if (cmdKey == `KEY_CLEAR) begin
            memWr   = 1'b1;
            memProt = 1'b0;
          end else if (cmdKey == `KEY_SET) begin
            memWr   = 1'b1;
            memProt = 1'b1;
          end else if (cmdKey == `KEY_LOCK) begin
            memWr   = 1'b1;
            memProt = 1'b1;
            memLock = 1'b1;
          end
          // Key 0 and keys above 3 leave memWr low
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // State registers
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cmdReg_ff    <= `CMD_RESET;
      statusSel_ff <= {`PERIPH_AW{1'b0}};
      state_ff     <= ST_IDLE;
      cmdValid_ff  <= 1'b0;
    end else begin
      cmdReg_ff    <= nxt_cmdReg;
      statusSel_ff <= nxt_statusSel;
      state_ff     <= nxt_state;
      // Identifiers past the implemented bridges are ignored
      cmdValid_ff  <= (bridgeOf(cmdId) < `NUM_BRIDGES);
    end
  end

  // Read data, registered, valid during the data phase
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      hrdata <= `ZERO32;
    end else if (addrPhase && !hwrite && hreadyout) begin
      if (haddr == `CMD_OFFSET) begin
        hrdata <= nxt_cmdReg;
      end else if (haddr == `STATUS_OFFSET) begin
        hrdata <= {29'h00000000, busyCmd, statusState};
      end else if (haddr == `STATUS_ID_OFFSET) begin
        hrdata <= {25'h0000000, nxt_statusSel};
      end else begin
        hrdata <= `ZERO32;
      end
    end
  end

endmodule // peripheral_write_guard

// [sim/test_peripheral_write_guard.sv]
// Self-checking bench for the write guard over single AHB-Lite words.
// Assumes the checker is bound separately; bus ready is the slave's own.
`timescale 1ns/1ps
`include "write_guard_defines.vh"
module test_peripheral_write_guard;
  reg          clk, reset, hsel, hwrite;
  reg  [7:0]   haddr;
  reg  [1:0]   htrans;
  reg  [2:0]   hsize;
  reg  [31:0]  hwdata, q;
  reg  [15:0]  tid;
  reg  [127:0] expVec;              // Expected protect vector
  wire [31:0]  hrdata;
  wire         hreadyout, hresp, busyCmd;
  wire [127:0] writeProtect;
  wire         hready = hreadyout;  // Lone slave drives the bus ready
  integer      miscompares, cmp_count, cycles, b;
  peripheral_write_guard DUT (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .writeProtect(writeProtect),
    .busyCmd(busyCmd));
  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Hang guard, far above the expected run
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
      miscompares = miscompares + 1;
      final_report;
    end
  end
  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // Ready and read data are taken at the rising edge, before its updates land
  task waitRdy;
    begin
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      q = hrdata;
    end
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    begin
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= `HTRANS_NONSEQ;
      hwrite <= w;
      waitRdy;
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      waitRdy;
    end
  endtask
  task chk(input [127:0] got, input [127:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Let a command land, then compare the whole vector
  task settle;
    begin
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk(writeProtect, expVec);
      @(posedge clk);
    end
  endtask
  task cmd(input [7:0] k, input [15:0] id);
    begin
      xfer(1'b1, `CMD_OFFSET, {8'h00, k, id});
      settle;
    end
  endtask
  initial begin
    miscompares = 0;
    cmp_count   = 0;
    cycles      = 0;
    expVec      = 128'h0;
    reset       = 1'b1;
    hsel        = 1'b0;
    haddr       = 8'h00;
    htrans      = 2'h0;
    hwrite      = 1'b0;
    hsize       = 3'h2;
    hwdata      = 32'h00000000;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    settle;
    xfer(1'b0, `CMD_OFFSET, 32'h0);
    chk(q, `CMD_RESET);
    chk(hresp, `HRESP_OKAY);
    $display("test reset done");
    for (b = 0; b < 4; b = b + 1) begin
      tid = b * 32 + (b == 3 ? 31 : b);
      expVec[tid] = 1'b1;
      cmd(`KEY_SET, tid);
      xfer(1'b0, `CMD_OFFSET, 32'h0);
      chk(q, {16'h0002, tid});
    end
    // Bridge 4 lies past the implemented bridges: slot 1 must stay clear
    cmd(`KEY_SET, 16'd129);
    $display("test bridges done");
    expVec[5] = 1'b1;
    cmd(`KEY_SET, 16'd5);
    cmd(`KEY_OFF, 16'd5);
    cmd(8'h04, 16'd5);
    cmd(8'hFF, 16'd5);
    expVec[5] = 1'b0;
    cmd(`KEY_CLEAR, 16'd5);
    $display("test keys done");
    expVec[40] = 1'b1;
    cmd(`KEY_LOCK, 16'd40);
    cmd(`KEY_CLEAR, 16'd40);
    xfer(1'b1, `STATUS_ID_OFFSET, 32'd40);
    xfer(1'b0, `STATUS_OFFSET, 32'h0);
    chk(q, 128'h3);
    xfer(1'b0, 8'h0C, 32'h0);
    chk(q, 128'h0);
    $display("test lock done");
    expVec[10] = 1'b1;
    expVec[11] = 1'b1;
    xfer(1'b1, `CMD_OFFSET, 32'h0002000A);
    xfer(1'b1, `CMD_OFFSET, 32'h0002000B);
    settle;
    $display("test back to back done");
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    expVec = 128'h0;
    settle;
    expVec[40] = 1'b1;
    cmd(`KEY_SET, 16'd40);
    expVec[40] = 1'b0;
    cmd(`KEY_CLEAR, 16'd40);
    $display("test second reset done");
    final_report;
  end
endmodule // test_peripheral_write_guard

// [sim/write_guard_checker.sv]
// Checker for the write guard: bus timing and protect vector relations.
// Assumes a bind onto peripheral_write_guard, one clock, async high reset.
`timescale 1ns/1ps
`include "write_guard_defines.vh"
module write_guard_checker (
  // Clock and reset
  input wire                   clk,
  input wire                   reset,
  // Bus side
  input wire                   hsel,
  input wire [`ADDR_W-1:0]     haddr,
  input wire [1:0]             htrans,
  input wire                   hwrite,
  input wire [2:0]             hsize,
  input wire                   hready,
  input wire [31:0]            hwdata,
  input wire [31:0]            hrdata,
  input wire                   hreadyout,
  input wire                   hresp,
  // Protection side
  input wire [`NUM_PERIPH-1:0] writeProtect,
  input wire                   busyCmd
);
  wire       addrPh = hsel & hready & htrans[1];  // Accepted address phase
  wire       takeCmd;                             // Command word taken
  reg        awCmd_ff;                            // Command write in data phase
  reg        arCmd_ff;                            // Command read in data phase
  reg  [3:0] since_ff;                            // Cycles since command, saturates
  reg  [6:0] lastId_ff;                           // Slot of last command
  assign takeCmd = awCmd_ff & hready;
  // Follow command phases; counter saturates so idle time never wraps
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      awCmd_ff  <= 1'b0;
      arCmd_ff  <= 1'b0;
      since_ff  <= 4'hF;
      lastId_ff <= 7'h00;
    end else begin
      if (hready) begin
        awCmd_ff <= addrPh & hwrite & (haddr == `CMD_OFFSET);
        arCmd_ff <= addrPh & ~hwrite & (haddr == `CMD_OFFSET);
      end
      if (takeCmd) begin
        since_ff  <= 4'h0;
        lastId_ff <= hwdata[6:0];
      end else if (since_ff != 4'hF) begin
        since_ff <= since_ff + 4'h1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_setCmd;
    takeCmd && hwdata[23:17] == 7'h01 && hwdata[15:7] == 9'h000;
  endsequence
  sequence s_bitOn;
    ##[1:6] writeProtect[lastId_ff];
  endsequence
  property p_resetClear;
    disable iff (1'b0) reset |=> writeProtect == 128'h0 && !busyCmd;
  endproperty
  property p_setBit;
    s_setCmd |-> s_bitOn;
  endproperty
  property p_oneSlot;
    !$stable(writeProtect) |-> $onehot(writeProtect ^ $past(writeProtect));
  endproperty
  property p_quiet;
    !$stable(writeProtect) |-> since_ff < 4'h8;
  endproperty
  property p_readNoWait;
    addrPh && !hwrite |=> hreadyout;
  endproperty
  property p_stallBound;
    !hreadyout |-> ##[1:2] hreadyout;
  endproperty
  property p_cmdTop;
    arCmd_ff && hready |-> hrdata[31:24] == 8'h00;
  endproperty
  property p_busyEnd;
    $rose(busyCmd) |-> ##[1:4] !busyCmd;
  endproperty
  a_resetClear: assert property (p_resetClear) else $error("protect not clear in reset");
  a_setBit: assert property (p_setBit) else $error("set key left slot open");
  a_oneSlot: assert property (p_oneSlot) else $error("several slots changed at once");
  a_quiet: assert property (p_quiet) else $error("protect changed without command");
  a_readNoWait: assert property (p_readNoWait) else $error("read stalled");
  a_stallBound: assert property (p_stallBound) else $error("write stall too long");
  a_cmdTop: assert property (p_cmdTop) else $error("command top byte not zero");
  a_busyEnd: assert property (p_busyEnd) else $error("command engine stuck busy");
endmodule // write_guard_checker
bind peripheral_write_guard write_guard_checker chk (.*);
